// ### core/serial_pkg.sv
// Constants and types shared by the serial channel frame and wakeup logic.
// Assumes a single 100 MHz system clock and a receive tick enable from outside.
package serial_pkg;
	localparam int unsigned TicksPerBit   = 16;
	localparam logic [3:0]  SampleFirst   = 4'h8;
	localparam logic [3:0]  SampleSecond  = 4'h9;
	localparam logic [3:0]  SampleThird   = 4'hA;
	localparam logic [3:0]  StartCheck    = 4'h7;
	localparam logic [3:0]  TickLast      = 4'hF;
	localparam logic [3:0]  BitsEight     = 4'h8;
	localparam logic [3:0]  BitsNine      = 4'h9;
	localparam logic [7:0]  StopDoneEight = 8'h9A;
	localparam logic [7:0]  StopDoneNine  = 8'hAA;
	localparam logic [3:0]  IdleBitsEight = 4'hA;
	localparam logic [3:0]  IdleBitsNine  = 4'hB;
	localparam int unsigned FifoDepth     = 8;
	localparam int unsigned WordWidth     = 9;

	typedef enum logic [1:0] {
		RxIdle,
		RxStart,
		RxData,
		RxStop
	} rx_state_t;

	typedef enum logic [1:0] {
		TxIdle,
		TxShift
	} tx_state_t;
endpackage

// ### core/fifo_if.sv
// Valid/ready word channel between the channel logic and its buffer.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ns
interface fifo_if;
	logic       [serial_pkg::WordWidth-1:0] data;
	logic                                   valid;
	logic                                   ready;
	modport source (output data, output valid, input ready);
	modport sink   (input data, input valid, output ready);
endinterface

// ### core/sync_fifo.sv
// Synchronous FIFO, width and depth as parameters, valid/ready both sides.
// Assumes one clock and a synchronous active high reset.
`timescale 1ns/1ns
module sync_fifo #(
	parameter int unsigned Width = 9,
	parameter int unsigned Depth = 8
) (
	input  wire logic clk_sys, // System clock
	input  wire logic srst,    // Synchronous reset
	fifo_if.sink      inPort,  // Filling side
	fifo_if.source    outPort  // Draining side
);
	localparam int unsigned PtrW = $clog2(Depth);

	typedef struct packed {
		logic [PtrW-1:0] wrPtr;
		logic [PtrW-1:0] rdPtr;
		logic [PtrW:0]   count;
	} fifo_state_t;

	fifo_state_t          st;
	fifo_state_t          next_st;
	logic     [Width-1:0] mem [Depth];
	logic                 doWrite;
	logic                 doRead;

	assign inPort.ready  = (st.count != (PtrW+1)'(Depth));
	assign outPort.valid = (st.count != '0);
	assign outPort.data  = mem[st.rdPtr];
	assign doWrite       = inPort.valid && inPort.ready;
	assign doRead        = outPort.valid && outPort.ready;

	always_comb begin
		next_st = st;
		if (doWrite) begin
			next_st.wrPtr = (st.wrPtr == PtrW'(Depth - 1)) ? '0 : st.wrPtr + 1'b1;
		end
		if (doRead) begin
			next_st.rdPtr = (st.rdPtr == PtrW'(Depth - 1)) ? '0 : st.rdPtr + 1'b1;
		end
		if (doWrite && !doRead) begin
			next_st.count = st.count + 1'b1;
		end else if (doRead && !doWrite) begin
			next_st.count = st.count - 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
		if (doWrite) begin
			mem[st.wrPtr] <= inPort.data;
		end
	end
endmodule // sync_fifo

// ### core/serial_frame_and_wakeup.sv
// Serial channel framing, 16x receive sampling, standby/wakeup, pin takeover.
// Assumes tick enables come from an outside baud divider; pins are synchronous.
// Contract
// [RULE_01] One start, eight or nine data, one stop
// [RULE_02] Length bit low: eight data, ten bits
// [RULE_03] Length bit high: nine data, eleven bits
// [RULE_04] Top data bit may mark an address
// [RULE_05] Ninth transmit bit sticky, reused each frame
// [RULE_06] Stop bit sampled at ticks eight, nine, ten
// [RULE_07] Sixteen ticks per bit; stop done 154/170
// [RULE_08] Standby request suppresses receiver interrupts
// [RULE_09] Standby still loads data, no full flag
// [RULE_10] Sender puts address in first frames
// [RULE_11] Exit method bit picks idle or address
// [RULE_12] Transmitter enabled takes pin five as output
// [RULE_13] Receiver enabled takes pin four as input
// [RULE_14] Pins are undriven inputs through reset
// [RULE_15] Address frame ends standby, clears request
// [RULE_16] Full idle character ends standby, clears request
`timescale 1ns/1ns
module serial_frame_and_wakeup (
	input  wire logic       clk_sys,                   // System clock
	input  wire logic       srst,                      // Synchronous reset
	input  wire logic       receiverSampleTick,        // 16x bit rate enable, receive
	input  wire logic       transmitterSampleTick,     // 16x bit rate enable, transmit
	input  wire logic       dataLengthSelect,          // 1 = nine data bits
	input  wire logic       wakeupMethod,              // 1 = address mark, 0 = idle line
	input  wire logic       transmitEnable,            // Transmitter enable
	input  wire logic       receiveEnable,             // Receiver enable
	input  wire logic       receiveIrqEnable,          // Receive interrupt enable
	input  wire logic       standbySet,                // Pulse: set standby request
	input  wire logic       ninthBitWrite,             // Pulse: load transmit ninth bit
	input  wire logic       ninthBitValue,             // Value for ninthBitWrite
	input  wire logic [7:0] txData,                    // Low transmit data byte
	input  wire logic       txValid,                   // Transmit byte offered
	output logic            txReady,                   // Transmit byte accepted
	input  wire logic       rxReadAck,                 // Pulse: software read, clears full
	output logic      [8:0] rxData,                    // Received data word
	output logic            receiveFullFlag,           // Received data waiting
	output logic            receiveIrq,                // Receive interrupt request
	output logic            receiverStandbyRequest,    // Standby state
	output logic            transmitNinthBit,          // Sticky ninth transmit bit
	input  wire logic       portMPinFourIn,            // Pin four input level
	output logic            portMPinFourOut,           // Pin four output level
	output logic            portMPinFourOe,            // Pin four output enable
	input  wire logic       portMPinFiveIn,            // Pin five input level
	output logic            portMPinFiveOut,           // Pin five output level
	output logic            portMPinFiveOe,            // Pin five output enable
	input  wire logic       portMPinFourGpioOut,       // Port logic level for pin four
	input  wire logic       portMPinFourGpioOe,        // Port logic enable for pin four
	input  wire logic       portMPinFiveGpioOut,       // Port logic level for pin five
	input  wire logic       portMPinFiveGpioOe         // Port logic enable for pin five
);
	typedef struct packed {
		serial_pkg::rx_state_t rxState;
		logic [3:0]            rxTick;
		logic [3:0]            rxBit;
		logic [8:0]            rxShift;
		logic [2:0]            stopVotes;
		logic [7:0]            frameTicks;
		logic [3:0]            idleBits;
		logic [3:0]            idleTick;
		logic [8:0]            rxData;
		logic                  full;
		logic                  standby;
		logic                  ninth;
		serial_pkg::tx_state_t txState;
		logic [3:0]            txTick;
		logic [3:0]            txBit;
		logic [10:0]           txShift;
		logic                  txLine;
	} chan_state_t;

	chan_state_t st;
	chan_state_t next_st;
	logic        serialInPin;
	logic        serialOutPin;
	logic [3:0]  dataBits;
	logic [7:0]  stopDone;
	logic [3:0]  idleTarget;
	logic        stopLevel;

	fifo_if txIn ();
	fifo_if txOut ();

	sync_fifo #(
		.Width(serial_pkg::WordWidth),
		.Depth(serial_pkg::FifoDepth)
	) txBuffer (
		.clk_sys(clk_sys),
		.srst   (srst),
		.inPort (txIn.sink),
		.outPort(txOut.source)
	);

	assign txIn.data  = {1'b0, txData};
	assign txIn.valid = txValid;
	assign txReady    = txIn.ready;
	assign txOut.ready = (st.txState == serial_pkg::TxIdle) && transmitEnable
		&& transmitterSampleTick;

	assign serialInPin = receiveEnable ? portMPinFourIn : 1'b1; // RULE_13
	assign serialOutPin = st.txLine;
	// Pins stay undriven while reset holds and until the port logic or channel claims them
	assign portMPinFiveOut = transmitEnable ? serialOutPin : portMPinFiveGpioOut; // RULE_12
	assign portMPinFiveOe  = srst ? 1'b0
		: (transmitEnable ? 1'b1 : portMPinFiveGpioOe); // RULE_14
	assign portMPinFourOut = portMPinFourGpioOut;
	assign portMPinFourOe  = (srst || receiveEnable) ? 1'b0 : portMPinFourGpioOe; // RULE_14

	assign dataBits   = dataLengthSelect ? serial_pkg::BitsNine : serial_pkg::BitsEight; // RULE_03
	assign stopDone   = dataLengthSelect ? serial_pkg::StopDoneNine
		: serial_pkg::StopDoneEight; // RULE_07
	assign idleTarget = dataLengthSelect ? serial_pkg::IdleBitsNine
		: serial_pkg::IdleBitsEight; // RULE_02
	assign stopLevel  = (st.stopVotes[0] & st.stopVotes[1])
		| (st.stopVotes[1] & st.stopVotes[2]) | (st.stopVotes[0] & st.stopVotes[2]);

	assign rxData                 = st.rxData;
	assign receiveFullFlag        = st.full;
	assign receiverStandbyRequest = st.standby;
	assign transmitNinthBit       = st.ninth;
	assign receiveIrq = st.full && receiveIrqEnable && !st.standby; // RULE_08

	always_comb begin
		next_st = st;
		if (rxReadAck) begin
			next_st.full = 1'b0;
		end
		if (ninthBitWrite) begin
			next_st.ninth = ninthBitValue; // RULE_05
		end
		if (standbySet) begin
			next_st.standby = 1'b1; // RULE_08
		end

		// Receiver, 16 ticks per bit, frame tick count from start edge
		if (!receiveEnable) begin
			next_st.rxState = serial_pkg::RxIdle;
		end else if (receiverSampleTick) begin
			next_st.rxTick     = st.rxTick + 1'b1; // RULE_07
			next_st.frameTicks = st.frameTicks + 1'b1;
			// Idle line wakeup counts whole bit times of steady mark
			if (serialInPin && st.rxState == serial_pkg::RxIdle) begin
				next_st.idleTick = st.idleTick + 1'b1;
				if (st.idleTick == serial_pkg::TickLast && st.idleBits != idleTarget) begin
					next_st.idleBits = st.idleBits + 1'b1;
				end
			end else begin
				next_st.idleTick = '0;
				next_st.idleBits = '0;
			end
			if (st.standby && !wakeupMethod && st.idleBits == idleTarget) begin // RULE_11
				next_st.standby = 1'b0; // RULE_16
			end
			unique case (st.rxState)
				serial_pkg::RxIdle: begin
					if (!serialInPin) begin
						next_st.rxState    = serial_pkg::RxStart;
						next_st.rxTick     = 4'h1;
						next_st.frameTicks = 8'h1;
					end
				end
				serial_pkg::RxStart: begin
					if (st.rxTick == serial_pkg::StartCheck && serialInPin) begin
						next_st.rxState = serial_pkg::RxIdle;
					end else if (st.rxTick == serial_pkg::TickLast) begin
						next_st.rxState = serial_pkg::RxData;
						next_st.rxBit   = '0;
					end
				end
				serial_pkg::RxData: begin
					if (st.rxTick == serial_pkg::SampleSecond) begin
						next_st.rxShift = {serialInPin, st.rxShift[8:1]}; // RULE_01
					end
					if (st.rxTick == serial_pkg::TickLast) begin
						next_st.rxBit = st.rxBit + 1'b1;
						if (st.rxBit + 1'b1 == dataBits) begin
							next_st.rxState   = serial_pkg::RxStop;
							next_st.stopVotes = '0;
						end
					end
				end
				serial_pkg::RxStop: begin
					// Votes at 8, 9 and 10 even when a fast stop bit ends at 10
					if (st.rxTick == serial_pkg::SampleFirst) begin
						next_st.stopVotes[0] = serialInPin; // RULE_06
					end
					if (st.rxTick == serial_pkg::SampleSecond) begin
						next_st.stopVotes[1] = serialInPin; // RULE_06
					end
					if (st.rxTick == serial_pkg::SampleThird
						&& st.frameTicks == stopDone) begin // RULE_07
						next_st.rxState = serial_pkg::RxIdle;
						if ((st.stopVotes[0] & st.stopVotes[1])
							| (serialInPin & (st.stopVotes[0] | st.stopVotes[1]))) begin // RULE_06
							next_st.rxData = dataLengthSelect ? st.rxShift
								: {1'b0, st.rxShift[8:1]}; // RULE_09
							if (st.standby) begin
								if (wakeupMethod && (dataLengthSelect ? st.rxShift[8]
									: st.rxShift[8])) begin // RULE_04
									next_st.standby = 1'b0; // RULE_15
									next_st.full    = 1'b1;
								end
							end else begin
								next_st.full = 1'b1; // RULE_09
							end
						end
					end
				end
			endcase
		end

		// Transmitter, start bit, data bits, ninth bit, stop bit
		if (!transmitEnable) begin
			next_st.txState = serial_pkg::TxIdle;
			next_st.txLine  = 1'b1;
		end else if (transmitterSampleTick) begin
			unique case (st.txState)
				serial_pkg::TxIdle: begin
					next_st.txLine = 1'b1;
					if (txOut.valid) begin
						next_st.txState = serial_pkg::TxShift;
						next_st.txShift = dataLengthSelect
							? {1'b1, st.ninth, txOut.data[7:0], 1'b0} // RULE_05
							: {1'b1, 1'b1, txOut.data[7:0], 1'b0}; // RULE_02
						next_st.txTick  = '0;
						next_st.txBit   = '0;
						next_st.txLine  = 1'b0;
					end
				end
				serial_pkg::TxShift: begin
					next_st.txTick = st.txTick + 1'b1;
					if (st.txTick == serial_pkg::TickLast) begin
						next_st.txBit   = st.txBit + 1'b1;
						next_st.txShift = {1'b1, st.txShift[10:1]};
						next_st.txLine  = st.txShift[1];
						if (st.txBit + 1'b1 == dataBits + 4'h2) begin // RULE_01
							next_st.txState = serial_pkg::TxIdle;
							next_st.txLine  = 1'b1;
						end
					end
				end
			endcase
		end
		// A new standby request in the same cycle as a wakeup wins
		if (standbySet) begin
			next_st.standby = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			st         <= '0;
			st.txLine  <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	logic unusedPin;
	assign unusedPin = portMPinFiveIn ^ stopLevel ^ txOut.data[8] ^ st.stopVotes[2];
endmodule // serial_frame_and_wakeup

// ### dv/serial_frame_and_wakeup_props.sv
// Checker: pin takeover, standby, ninth bit and interrupt gating.
// Sees only the top ports; bound to every instance after the module.
`timescale 1ns/1ns
module serial_frame_and_wakeup_props (
	input wire logic clk_sys,                // Clock
	input wire logic srst,                   // Reset
	input wire logic transmitEnable,         // Tx on
	input wire logic receiveEnable,          // Rx on
	input wire logic receiveIrqEnable,       // Irq on
	input wire logic standbySet,             // Standby pulse
	input wire logic ninthBitWrite,          // Ninth load
	input wire logic ninthBitValue,          // Ninth value
	input wire logic receiveFullFlag,        // Full
	input wire logic receiveIrq,             // Irq
	input wire logic receiverStandbyRequest, // Standby
	input wire logic transmitNinthBit,       // Ninth bit
	input wire logic portMPinFourOe,         // Pin four enable
	input wire logic portMPinFiveOut,        // Pin five level
	input wire logic portMPinFiveOe          // Pin five enable
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	chk_reset_pins_off: assert property (disable iff (1'b0)
		srst && $past(srst) |-> !portMPinFourOe && !portMPinFiveOe)
		else $error("pin driven in reset");
	chk_rx_pin_input: assert property (
		receiveEnable && $past(receiveEnable) |-> !portMPinFourOe)
		else $error("pin four driven while receiving");
	chk_tx_pin_output: assert property (
		transmitEnable && $past(transmitEnable) |-> portMPinFiveOe)
		else $error("pin five not driven while transmitting");
	chk_irq_gating: assert property (
		receiveIrq == (receiveFullFlag && receiveIrqEnable && !receiverStandbyRequest))
		else $error("interrupt gating wrong");
	chk_standby_no_full: assert property (
		$rose(receiveFullFlag) |-> !receiverStandbyRequest)
		else $error("full set in standby");
	chk_standby_set: assert property (
		standbySet |=> receiverStandbyRequest)
		else $error("standby not entered");
	chk_ninth_load: assert property (
		ninthBitWrite |=> transmitNinthBit == $past(ninthBitValue))
		else $error("ninth bit not loaded");
	chk_ninth_sticky: assert property (
		!ninthBitWrite |=> $stable(transmitNinthBit))
		else $error("ninth bit changed");
	chk_start_bit_hold: assert property (
		$fell(portMPinFiveOut) && transmitEnable |-> !portMPinFiveOut [*8])
		else $error("start bit too short");
endmodule // serial_frame_and_wakeup_props

bind serial_frame_and_wakeup serial_frame_and_wakeup_props chk (.*);

// ### dv/serial_peer.sv
// Remote serial node: sends frames to the device, decodes what it sends.
// Assumes the frame length stays steady during a frame.
`timescale 1ns/1ns
module serial_peer #(
	parameter int BitCycles = 64
) (
	input  wire logic clk_sys,  // Clock
	input  wire logic nineBits, // Nine data bits
	input  wire logic lineIn,   // Device output
	output logic      lineOut   // Device input
);
	logic [9:0] got[$];
	initial lineOut = 1'b1;
	// Line rests at mark between frames
	task automatic sendFrame(input logic [8:0] w, input int bc);
		logic [10:0] f;
		f = nineBits ? {1'b1, w, 1'b0} : {2'b11, w[7:0], 1'b0};
		for (int i = 0; i < (nineBits ? 11 : 10); i++) begin
			lineOut = f[i];
			repeat (bc) @(negedge clk_sys);
		end
	endtask
	always begin : decode
		logic [9:0] w;
		logic       n;
		@(negedge lineIn);
		n = nineBits;
		w = '0;
		repeat (BitCycles / 2) @(posedge clk_sys);
		for (int i = 0; i < (n ? 10 : 9); i++) begin
			repeat (BitCycles) @(posedge clk_sys);
			w[i] = lineIn;
		end
		got.push_back(n ? w : {w[8], 1'b0, w[7:0]});
	end
endmodule // serial_peer

// ### dv/tb.sv
// Bench: peer node on the pins, queue models for both directions.
// Ticks every 4 clocks, so one bit lasts 64 clocks.
`timescale 1ns/1ns
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
$display("BAD %s exp %0h got %0h", n, e, g); end end
module tb;
	localparam int BitCyc = 64;
	logic       clk_sys = 0, srst = 1, receiverSampleTick = 0, transmitterSampleTick = 0;
	logic       dataLengthSelect = 0, wakeupMethod = 0, transmitEnable = 0, receiveEnable = 0;
	logic       receiveIrqEnable = 0, standbySet = 0, ninthBitWrite = 0, ninthBitValue = 0;
	logic       txValid = 0, rxReadAck = 0, sawFull = 0, ninthExp = 0, peerLine;
	logic       txReady, receiveFullFlag, receiveIrq, receiverStandbyRequest, transmitNinthBit;
	logic       portMPinFourIn, portMPinFourOut, portMPinFourOe;
	logic       portMPinFiveIn, portMPinFiveOut, portMPinFiveOe;
	logic       portMPinFourGpioOut = 0, portMPinFourGpioOe = 1;
	logic       portMPinFiveGpioOut = 0, portMPinFiveGpioOe = 1;
	logic [7:0] txData = 0;
	logic [8:0] rxData, rxExp[$];
	logic [9:0] txExp[$], ev, gv;
	int         bad_count = 0, tests_run = 0, cyc = 0;
	assign portMPinFourIn = portMPinFourOe ? portMPinFourOut : peerLine;
	assign portMPinFiveIn = portMPinFiveOe ? portMPinFiveOut : 1'b1;
	serial_frame_and_wakeup dut (.*);
	serial_peer #(.BitCycles(BitCyc)) peer (
		.clk_sys  (clk_sys),
		.nineBits (dataLengthSelect),
		.lineIn   (portMPinFiveIn),
		.lineOut  (peerLine)
	);
	initial begin
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic complete_run;
		if (bad_count == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// Ticks, read acknowledge, both scoreboards and the hang limit
	always @(negedge clk_sys) begin
		cyc <= cyc + 1;
		receiverSampleTick <= cyc % 4 == 0;
		transmitterSampleTick <= cyc % 4 == 2;
		rxReadAck <= 1'b0;
		if (receiveFullFlag === 1'b1 && !rxReadAck) begin
			ev = 10'(rxExp.pop_front());
			gv = 10'(rxData);
			`CHK("rxData", ev, gv)
			`CHK("rxIrq", 1'b1, receiveIrq)
			rxReadAck <= 1'b1;
		end
		if (peer.got.size() > 0) begin
			ev = txExp.pop_front();
			gv = peer.got.pop_front();
			`CHK("txFrame", ev, gv)
		end
		if (cyc > 40000) begin
			bad_count++;
			complete_run();
		end
	end
	task automatic pulse(ref logic s);
		s = 1'b1;
		@(negedge clk_sys);
		s = 1'b0;
	endtask
	task automatic sendTx(input int n);
		repeat (n) begin
			txData = 8'($urandom);
			txValid = 1'b1;
			// Ready is settled on the falling edge, ahead of the edge that takes the word
			while (txReady !== 1'b1) begin
				sawFull = 1'b1;
				@(negedge clk_sys);
			end
			txExp.push_back({1'b1, dataLengthSelect & ninthExp, txData});
			@(negedge clk_sys);
		end
		txValid = 1'b0;
	endtask
	task automatic rxTimed(input int ticks);
		logic [8:0] w;
		int         n;
		w = 9'($urandom);
		n = 0;
		rxExp.push_back(dataLengthSelect ? w : {1'b0, w[7:0]});
		fork
			peer.sendFrame(w, BitCyc);
			while (receiveFullFlag !== 1'b1 && n < 2000) begin
				@(negedge clk_sys);
				n++;
			end
		join
		`CHK("doneTime", 1'b1, n inside {[ticks * 4 - 6 : ticks * 4 + 14]})
	endtask
	initial begin
		logic [8:0] w;
		w = 9'($urandom(61006));
		repeat (2) @(negedge clk_sys);
		srst = 1'b0;
		{transmitEnable, receiveEnable, receiveIrqEnable, dataLengthSelect} = 4'hF;
		{portMPinFourGpioOut, portMPinFiveGpioOut, ninthExp} = 3'($urandom);
		ninthBitValue = ninthExp;
		pulse(ninthBitWrite);
		`CHK("ninthBit", ninthExp, transmitNinthBit)
		sendTx(12);
		`CHK("refused", 1'b1, sawFull)
		wait (txExp.size() == 0);
		rxTimed(170);
		rxExp.push_back(w);
		rxExp.push_back(~w);
		peer.sendFrame(w, 62);
		peer.sendFrame(~w, 62);
		repeat (BitCyc) @(negedge clk_sys);
		dataLengthSelect = 1'b0;
		sendTx(2);
		wait (txExp.size() == 0);
		rxTimed(154);
		wakeupMethod = 1'b1;
		pulse(standbySet);
		w = {2'b00, 7'($urandom)};
		peer.sendFrame(w, BitCyc);
		repeat (12 * BitCyc) @(negedge clk_sys);
		`CHK("loaded", w, rxData)
		`CHK("asleep", 1'b1, receiverStandbyRequest)
		w[7] = 1'b1;
		rxExp.push_back(w);
		peer.sendFrame(w, BitCyc);
		repeat (BitCyc) @(negedge clk_sys);
		`CHK("addrWake", 1'b0, receiverStandbyRequest)
		wakeupMethod = 1'b0;
		pulse(standbySet);
		peer.sendFrame(w, BitCyc);
		repeat (4 * BitCyc) @(negedge clk_sys);
		`CHK("idleWait", 1'b1, receiverStandbyRequest)
		repeat (8 * BitCyc) @(negedge clk_sys);
		`CHK("idleWake", 1'b0, receiverStandbyRequest)
		{transmitEnable, receiveEnable} = 2'b00;
		repeat (2) @(negedge clk_sys);
		`CHK("pinFive", {1'b1, portMPinFiveGpioOut}, {portMPinFiveOe, portMPinFiveOut})
		`CHK("pinFour", {1'b1, portMPinFourGpioOut}, {portMPinFourOe, portMPinFourOut})
		complete_run();
	end
endmodule // tb
